/* jcb_cpu_bus_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module jcb_cpu_bus_ctl
  import jcb_pkg::*;
#(
  parameter bit NEWER_VARIANT = 1'b0
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Test port pins.
  input  wire logic         tck_in,
  input  wire logic         tms_in,
  input  wire logic         tdi_in,
  output var  logic         tdo_out,
  output var  logic         tdo_oe_out,
  // Target clock pin.
  input  wire logic         target_system_clock_in,
  // CPU status.
  input  wire logic [15:0]  cpu_pc_in,
  input  wire logic [15:0]  jtag_addr_in,
  input  wire logic [15:0]  mdb_in,
  input  wire logic         cpu_rw_in,
  input  wire logic         cpu_byte_in,
  input  wire logic         fetch_state_flag_in,
  input  wire logic         cpu_sync_flag_in,
  input  wire logic         cpu_wait_in,
  // Memory buses and CPU control.
  output var  logic [15:0]  memory_address_bus_out,
  output var  logic [15:0]  memory_data_bus_out,
  output var  logic         mdb_drive_out,
  output var  logic         pc_inc_out,
  output var  jcb_cpu_ctl_t cpu_ctl_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  logic [PIN_NUM-1:0] pins_s;
  logic               tck_rise;
  logic               tck_fall;
  logic               target_system_clock_fall;
  logic               wide_dr;
  logic               switch_on;
  logic [15:0]        ctrl_rd;
  logic [15:0]        wr_mask;
  jcb_state_t         st_q;
  jcb_state_t         st_d;

  jcb_pin_sync u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pins_in  ({target_system_clock_in, tdi_in, tms_in, tck_in}),
    .pins_out (pins_s)
  );

  assign tck_rise  = pins_s[PIN_TCK] & ~st_q.tck_prev;
  assign tck_fall  = ~pins_s[PIN_TCK] & st_q.tck_prev;
  assign target_system_clock_fall = ~pins_s[PIN_TARGET_SYSTEM_CLOCK] & st_q.target_system_clock_prev;
  assign wide_dr   = (st_q.ir == QUICK_DATA_INSTR) || (st_q.ir == CTRL_WRITE_INSTR)
                     || (st_q.ir == CTRL_READ_INSTR);
  assign switch_on = ~NEWER_VARIANT & st_q.ctrl[BIT_SWITCH];
  assign wr_mask   = NEWER_VARIANT ? NEWER_WR_MASK : LEGACY_WR_MASK;

  // Read view of the control word with live status bits.
  always_comb begin
    ctrl_rd            = st_q.ctrl & wr_mask;
    ctrl_rd[BIT_FETCH] = fetch_state_flag_in;
    ctrl_rd[BIT_SYNC]  = cpu_sync_flag_in;
    if (NEWER_VARIANT) begin
      ctrl_rd[BIT_WAIT] = cpu_wait_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Controller state and next-state function.

  function automatic jcb_tap_t tap_next(input jcb_tap_t s, input logic tms);
    case (s)
      TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  endfunction

  always_comb begin
    st_d           = st_q;
    st_d.tck_prev  = pins_s[PIN_TCK];
    st_d.target_system_clock_prev = pins_s[PIN_TARGET_SYSTEM_CLOCK];
    st_d.pc_inc    = 1'b0;
    if (tck_rise) begin
      st_d.tap = tap_next(st_q.tap, pins_s[PIN_TMS]);
      case (st_q.tap)
        TAP_CAP_DR: begin
          if (st_q.ir == QUICK_DATA_INSTR) begin
            st_d.dr_sh = mdb_in;
          end else if (wide_dr) begin
            st_d.dr_sh = ctrl_rd;
          end else begin
            st_d.dr_sh = 16'h0000;
          end
        end
        TAP_SH_DR: begin
          if (wide_dr) begin
            st_d.dr_sh = {pins_s[PIN_TDI], st_q.dr_sh[15:1]};
          end else begin
            st_d.dr_sh[0] = pins_s[PIN_TDI];
          end
        end
        TAP_CAP_IR: st_d.ir_sh = IR_CAPTURE_VAL;
        TAP_SH_IR:  st_d.ir_sh = {pins_s[PIN_TDI], st_q.ir_sh[7:1]};
        default:    st_d.ir_sh = st_q.ir_sh;
      endcase
    end
    if (tck_fall) begin
      st_d.tdo_oe = 1'b0;
      case (st_q.tap)
        TAP_SH_DR: begin
          st_d.tdo    = st_q.dr_sh[0];
          st_d.tdo_oe = ~switch_on;
        end
        TAP_SH_IR: begin
          st_d.tdo    = st_q.ir_sh[0];
          st_d.tdo_oe = ~switch_on;
        end
        TAP_UP_IR: begin
          st_d.ir = st_q.ir_sh;
          if (st_q.ir_sh == PASS_THROUGH_INSTR) begin
            st_d.ctrl[BIT_HOST_CTRL] = 1'b0;
            st_d.ctrl[BIT_HALT]      = 1'b0;
          end
        end
        TAP_UP_DR: begin
          if (st_q.ir == QUICK_DATA_INSTR) begin
            st_d.memory_data_bus       = st_q.dr_sh;
            st_d.mdb_drive = 1'b1;
          end else if (st_q.ir == CTRL_WRITE_INSTR) begin
            st_d.ctrl = st_q.dr_sh & wr_mask;
          end
        end
        default: st_d.ir = st_q.ir;
      endcase
    end
    if (st_q.tap == TAP_RESET) begin
      st_d.ir = PASS_THROUGH_INSTR;
    end
    if (st_d.ir != QUICK_DATA_INSTR) begin
      st_d.mdb_drive = 1'b0;
    end
    if (st_q.ir == QUICK_DATA_INSTR) begin
      st_d.memory_address_bus = cpu_pc_in;
      if (target_system_clock_fall && (st_q.tap == TAP_IDLE)) begin
        st_d.pc_inc = 1'b1;
      end
    end else begin
      st_d.memory_address_bus = jtag_addr_in;
    end
    if (~NEWER_VARIANT && st_q.ctrl[BIT_LOW_RELEASE]) begin
      st_d.cpu_ctl.rw       = cpu_rw_in;
      st_d.cpu_ctl.byte_acc = cpu_byte_in;
    end else begin
      st_d.cpu_ctl.rw       = st_q.ctrl[BIT_RW];
      st_d.cpu_ctl.byte_acc = st_q.ctrl[BIT_BYTE];
    end
    st_d.cpu_ctl.halt             = ~NEWER_VARIANT & st_q.ctrl[BIT_HALT];
    st_d.cpu_ctl.host_control_bit = st_q.ctrl[BIT_HOST_CTRL];
    st_d.cpu_ctl.por              = st_q.ctrl[BIT_POR];
    st_d.cpu_ctl.flash_master_select = NEWER_VARIANT | st_q.ctrl[BIT_FLASH_SEL];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q      <= '0;
      st_q.ir   <= PASS_THROUGH_INSTR;
      st_q.ctrl <= NEWER_VARIANT ? NEWER_RST : LEGACY_RST;
      st_q.cpu_ctl.flash_master_select <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign tdo_out                = st_q.tdo;
  assign tdo_oe_out             = st_q.tdo_oe;
  assign memory_address_bus_out = st_q.memory_address_bus;
  assign memory_data_bus_out    = st_q.memory_data_bus;
  assign mdb_drive_out          = st_q.mdb_drive;
  assign pc_inc_out             = st_q.pc_inc;
  assign cpu_ctl_out            = st_q.cpu_ctl;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence update_ir_s;
    tck_fall && (st_q.tap == TAP_UP_IR);
  endsequence

  sequence update_dr_quick_s;
    tck_fall && (st_q.tap == TAP_UP_DR) && (st_q.ir == QUICK_DATA_INSTR);
  endsequence

  quick_load_a: assert property (update_dr_quick_s |=>
    (memory_data_bus_out == $past(st_q.dr_sh)) && mdb_drive_out)
    else $error("quick data load missed");
  quick_addr_a: assert property ((st_q.ir == QUICK_DATA_INSTR) |=>
    memory_address_bus_out == $past(cpu_pc_in))
    else $error("address bus not from counter");
  pc_step_a: assert property (
    (target_system_clock_fall && st_q.ir == QUICK_DATA_INSTR && st_q.tap == TAP_IDLE)
    |=> pc_inc_out ##1 !pc_inc_out)
    else $error("counter step pulse wrong");
  bypass_echo_a: assert property (
    (tck_rise && st_q.tap == TAP_SH_DR && st_q.ir == PASS_THROUGH_INSTR)
    |=> st_q.dr_sh[0] == $past(pins_s[PIN_TDI]))
    else $error("pass-through bit not taken");
  bypass_release_a: assert property ((update_ir_s ##0 st_q.ir_sh == PASS_THROUGH_INSTR)
    |-> ##2 !cpu_ctl_out.host_control_bit)
    else $error("release not done");
  bypass_hold_a: assert property (
    (st_q.ir == PASS_THROUGH_INSTR) && !(tck_fall && (st_q.tap == TAP_UP_IR))
    |=> $stable(st_q.ctrl) && $stable(st_q.memory_data_bus))
    else $error("register changed under pass-through");
  por_drive_a: assert property (##1 cpu_ctl_out.por == $past(st_q.ctrl[BIT_POR]))
    else $error("reset output wrong");
  ir_update_a: assert property (update_ir_s |=> st_q.ir == $past(st_q.ir_sh))
    else $error("instruction not applied");
  switch_oe_a: assert property (switch_on |=> !tdo_oe_out)
    else $error("output enabled while switched");

  ////////////////////////////////////////////////////////////////////////////////
  // Data path, control word and status assertions.

  sequence capture_dr_s;
    tck_rise && (st_q.tap == TAP_CAP_DR);
  endsequence

  sequence update_dr_write_s;
    tck_fall && (st_q.tap == TAP_UP_DR) && (st_q.ir == CTRL_WRITE_INSTR);
  endsequence

  sequence shift_dr_fall_s;
    tck_fall && (st_q.tap == TAP_SH_DR);
  endsequence

  quick_capture_a: assert property ((capture_dr_s ##0 (st_q.ir == QUICK_DATA_INSTR))
    |=> st_q.dr_sh == $past(mdb_in))
    else $error("data bus not captured");
  dr_shift_a: assert property ((tck_rise && st_q.tap == TAP_SH_DR && wide_dr) |=>
    st_q.dr_sh == {$past(pins_s[PIN_TDI]), $past(st_q.dr_sh[15:1])})
    else $error("data bit not shifted");
  mab_jtag_a: assert property ((st_q.ir != QUICK_DATA_INSTR) |=>
    memory_address_bus_out == $past(jtag_addr_in))
    else $error("address bus not from address register");
  pc_quiet_a: assert property ((st_q.ir != QUICK_DATA_INSTR) |=> !pc_inc_out)
    else $error("counter step outside quick data");
  tdo_shift_a: assert property (shift_dr_fall_s |=> tdo_out == $past(st_q.dr_sh[0]))
    else $error("shift output bit wrong");
  release_halt_a: assert property ((update_ir_s ##0 (st_q.ir_sh == PASS_THROUGH_INSTR))
    |=> !st_q.ctrl[BIT_HOST_CTRL] && !st_q.ctrl[BIT_HALT])
    else $error("release left control bits set");
  ctrl_write_a: assert property (update_dr_write_s |=>
    st_q.ctrl == ($past(st_q.dr_sh) & wr_mask))
    else $error("control word not written");
  status_read_a: assert property (
    (capture_dr_s ##0 ((st_q.ir == CTRL_READ_INSTR) || (st_q.ir == CTRL_WRITE_INSTR)))
    |=> (st_q.dr_sh[BIT_FETCH] == $past(fetch_state_flag_in))
    && (st_q.dr_sh[BIT_SYNC] == $past(cpu_sync_flag_in)))
    else $error("status bits not captured");
  wait_read_a: assert property (
    (capture_dr_s ##0 (NEWER_VARIANT && (st_q.ir == CTRL_READ_INSTR)))
    |=> st_q.dr_sh[BIT_WAIT] == $past(cpu_wait_in))
    else $error("wait flag not captured");
  ir_shift_a: assert property ((tck_rise && st_q.tap == TAP_SH_IR) |=>
    st_q.ir_sh == {$past(pins_s[PIN_TDI]), $past(st_q.ir_sh[7:1])})
    else $error("instruction bit not shifted");
  rw_drive_a: assert property ((NEWER_VARIANT || !st_q.ctrl[BIT_LOW_RELEASE]) |=>
    cpu_ctl_out.rw == $past(st_q.ctrl[BIT_RW]))
    else $error("direction output wrong");
  byte_drive_a: assert property ((NEWER_VARIANT || !st_q.ctrl[BIT_LOW_RELEASE]) |=>
    cpu_ctl_out.byte_acc == $past(st_q.ctrl[BIT_BYTE]))
    else $error("width output wrong");
  low_release_a: assert property ((!NEWER_VARIANT && st_q.ctrl[BIT_LOW_RELEASE]) |=>
    (cpu_ctl_out.rw == $past(cpu_rw_in)) && (cpu_ctl_out.byte_acc == $past(cpu_byte_in)))
    else $error("direction and width not handed over");
  halt_drive_a: assert property (##1 cpu_ctl_out.halt ==
    (!NEWER_VARIANT && $past(st_q.ctrl[BIT_HALT])))
    else $error("halt output wrong");
  host_ctrl_a: assert property (##1 cpu_ctl_out.host_control_bit ==
    $past(st_q.ctrl[BIT_HOST_CTRL]))
    else $error("test control output wrong");
  flash_sel_a: assert property (##1 cpu_ctl_out.flash_master_select ==
    (NEWER_VARIANT || $past(st_q.ctrl[BIT_FLASH_SEL])))
    else $error("flash master output wrong");
  quick_decode_a: assert property ((st_q.ir != QUICK_DATA_INSTR) |=> !mdb_drive_out)
    else $error("bus driven outside quick data");

endmodule // jcb_cpu_bus_ctl
`default_nettype wire

/* jcb_pkg.sv */
`default_nettype none
package jcb_pkg;

  // Test access port controller states.
  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SH_DR   = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PA_DR   = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UP_DR   = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'hA,
    TAP_SH_IR   = 4'hB,
    TAP_EX1_IR  = 4'hC,
    TAP_PA_IR   = 4'hD,
    TAP_EX2_IR  = 4'hE,
    TAP_UP_IR   = 4'hF
  } jcb_tap_t;

  // Instruction codes.
  localparam logic [7:0] QUICK_DATA_INSTR   = 8'h43;
  localparam logic [7:0] PASS_THROUGH_INSTR = 8'hFF;
  localparam logic [7:0] CTRL_WRITE_INSTR   = 8'h13;
  localparam logic [7:0] CTRL_READ_INSTR    = 8'h14;
  localparam logic [7:0] IR_CAPTURE_VAL     = 8'h01;

  // Control word bit positions.
  localparam int BIT_RW          = 0;
  localparam int BIT_WAIT        = 3;
  localparam int BIT_HALT        = 3;
  localparam int BIT_BYTE        = 4;
  localparam int BIT_FETCH       = 7;
  localparam int BIT_SYNC        = 9;
  localparam int BIT_HOST_CTRL   = 10;
  localparam int BIT_POR         = 11;
  localparam int BIT_LOW_RELEASE = 12;
  localparam int BIT_FLASH_SEL   = 13;
  localparam int BIT_SWITCH      = 14;

  // Writable bits and reset values per variant.
  localparam logic [15:0] LEGACY_WR_MASK = 16'h7C19;
  localparam logic [15:0] NEWER_WR_MASK  = 16'h0C11;
  localparam logic [15:0] LEGACY_RST     = 16'h2000;
  localparam logic [15:0] NEWER_RST      = 16'h0000;

  // Program counter step in quick data mode.
  localparam logic [15:0] PC_STEP = 16'h0002;

  // Pin sampling order of the synchroniser vector.
  localparam int PIN_TCK  = 0;
  localparam int PIN_TMS  = 1;
  localparam int PIN_TDI  = 2;
  localparam int PIN_TARGET_SYSTEM_CLOCK = 3;
  localparam int PIN_NUM  = 4;

  typedef struct packed {
    logic rw;
    logic byte_acc;
    logic halt;
    logic host_control_bit;
    logic por;
    logic flash_master_select;
  } jcb_cpu_ctl_t;

  typedef struct packed {
    jcb_tap_t     tap;
    logic [7:0]   ir;
    logic [7:0]   ir_sh;
    logic [15:0]  dr_sh;
    logic [15:0]  ctrl;
    logic [15:0]  memory_data_bus;
    logic         mdb_drive;
    logic [15:0]  memory_address_bus;
    logic         pc_inc;
    logic         tdo;
    logic         tdo_oe;
    logic         tck_prev;
    logic         target_system_clock_prev;
    jcb_cpu_ctl_t cpu_ctl;
  } jcb_state_t;

endpackage
`default_nettype wire

/* jcb_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module jcb_pin_sync
  import jcb_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // Pins and synchronised levels.
  input  wire logic [PIN_NUM-1:0] pins_in,
  output var  logic [PIN_NUM-1:0] pins_out
);

  logic [PIN_NUM-1:0] meta_q;

  // Each pin passes two flip-flops before any logic reads it.
  for (genvar i = 0; i < PIN_NUM; i++) begin : g_sync
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        meta_q[i]   <= 1'b0;
        pins_out[i] <= 1'b0;
      end else begin
        meta_q[i]   <= pins_in[i];
        pins_out[i] <= meta_q[i];
      end
    end
  end

endmodule // jcb_pin_sync
`default_nettype wire

/* jcb_jtag_host.sv */
`timescale 1ns/1ps
`default_nettype none
module jcb_jtag_host
  import jcb_pkg::*;
(
  // Test port pins driven by the host.
  output var  logic tck_out,
  output var  logic tms_out,
  output var  logic tdi_out,
  output var  logic target_system_clock_out,
  // Returned test data.
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  localparam realtime HALF = 62.5;
  logic tdo_line;

  // A released data line shows the inverse of its last value.
  assign tdo_line = tdo_oe_in ? tdo_in : ~tdo_in;

  initial begin
    tck_out  = 1'b0;
    tms_out  = 1'b1;
    tdi_out  = 1'b0;
    target_system_clock_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One test clock period; pins change while the test clock is low.
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #HALF tck_out = 1'b1;
    tdo = tdo_line;
    #HALF tck_out = 1'b0;
  endtask

  // Walks to Test-Logic-Reset and then to Run-Test/Idle.
  task automatic to_idle();
    logic b;
    for (int i = 0; i < 6; i++) begin
      tick(i < 5, 1'b0, b);
    end
  endtask

  // Shifts n bits from Run-Test/Idle and returns to it.
  task automatic shift(input logic ir, input logic [15:0] din, input int n,
                       output logic [15:0] dout);
    logic b;
    dout = 16'h0000;
    tick(1'b1, 1'b0, b);
    if (ir) begin
      tick(1'b1, 1'b0, b);
    end
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask

  // One target clock period, given only in Run-Test/Idle.
  task automatic target_system_clock_pulse();
    #HALF target_system_clock_out = 1'b1;
    #HALF target_system_clock_out = 1'b0;
    #HALF;
  endtask
endmodule  // jcb_jtag_host
`default_nettype wire

/* jcb_cpu_bus_ctl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module jcb_cpu_bus_ctl_tb
  import jcb_pkg::*;
;
  typedef struct packed {
    logic [15:0] word;
    logic [5:0]  ctl;
  } jcb_row_t;

  logic         clk_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         tck, tms, tdi, target_system_clock, tdo, tdo_oe;
  logic [15:0]  cpu_pc_in = 16'h0000;
  logic [15:0]  mdb_in = 16'h0000;
  logic         fetch_in = 1'b1;
  logic         sync_in = 1'b0;
  logic [15:0]  memory_address_bus, memory_data_bus, got, prev, n0;
  logic [15:0]  pc_cnt = 16'h0000;
  logic         mdb_drive, pc_inc;
  jcb_cpu_ctl_t ctl;
  logic [5:0]   ctl_w;
  int           error_cnt = 0;
  int           num_checks = 0;
  jcb_row_t     rows [5] = '{'{16'h0001, 6'h20}, '{16'h2418, 6'h1D}, '{16'h0800, 6'h02},
                             '{16'h1011, 6'h10}, '{16'h1800, 6'h12}};

  assign ctl_w = ctl;
  always #2 clk_in = ~clk_in;

  jcb_cpu_bus_ctl #(.NEWER_VARIANT(1'b0)) u_jcb_cpu_bus_ctl (
    .clk_in(clk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .target_system_clock_in(target_system_clock),
    .cpu_pc_in(cpu_pc_in), .jtag_addr_in(16'h1234), .mdb_in(mdb_in),
    .cpu_rw_in(1'b0), .cpu_byte_in(1'b1), .fetch_state_flag_in(fetch_in),
    .cpu_sync_flag_in(sync_in), .cpu_wait_in(1'b0), .memory_address_bus_out(memory_address_bus),
    .memory_data_bus_out(memory_data_bus), .mdb_drive_out(mdb_drive), .pc_inc_out(pc_inc),
    .cpu_ctl_out(ctl));

  jcb_jtag_host u_jcb_jtag_host (
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .target_system_clock_out(target_system_clock),
    .tdo_in(tdo), .tdo_oe_in(tdo_oe));

  // The CPU steps its program counter on each increment request.
  always @(negedge clk_in) begin
    if (pc_inc === 1'b1) begin
      cpu_pc_in <= cpu_pc_in + PC_STEP;
      pc_cnt    <= pc_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] act);
    num_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, act);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    error_cnt++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    u_jcb_jtag_host.to_idle();
    chk("cpu_ctl", 16'h0001, {10'h000, ctl_w});
    chk("tdo_oe", 16'h0000, {15'h0000, tdo_oe});
    u_jcb_jtag_host.shift(1'b1, {8'h00, CTRL_WRITE_INSTR}, 8, got);
    prev = LEGACY_RST;
    foreach (rows[i]) begin
      u_jcb_jtag_host.shift(1'b0, rows[i].word, 16, got);
      chk("readback", (prev & LEGACY_WR_MASK) | 16'h0080, got);
      chk("cpu_ctl", {10'h000, rows[i].ctl}, {10'h000, ctl_w});
      prev = rows[i].word;
    end
    u_jcb_jtag_host.shift(1'b0, 16'h4000, 16, got);
    chk("readback", (prev & LEGACY_WR_MASK) | 16'h0080, got);
    chk("cpu_ctl", 16'h0000, {10'h000, ctl_w});
    u_jcb_jtag_host.shift(1'b0, 16'h2408, 16, got);
    chk("switch", 16'hBF7F, got);
    // Quick read and write of RAM words; the counter is loaded before the instruction.
    @(negedge clk_in);
    cpu_pc_in = 16'h0200;
    mdb_in = 16'hA5C3;
    u_jcb_jtag_host.shift(1'b1, {8'h00, QUICK_DATA_INSTR}, 8, got);
    chk("mab", 16'h0200, memory_address_bus);
    u_jcb_jtag_host.shift(1'b0, 16'h5A3C, 16, got);
    chk("tdo word", 16'hA5C3, got);
    chk("mdb", 16'h5A3C, memory_data_bus);
    chk("mdb_drive", 16'h0001, {15'h0000, mdb_drive});
    n0 = pc_cnt;
    repeat (2) u_jcb_jtag_host.target_system_clock_pulse();
    chk("pc steps", 16'h0002, pc_cnt - n0);
    chk("mab", 16'h0204, memory_address_bus);
    // Pass-through releases the CPU and then holds the control word and the data bus.
    u_jcb_jtag_host.shift(1'b1, {8'h00, PASS_THROUGH_INSTR}, 8, got);
    chk("cpu_ctl", 16'h0001, {10'h000, ctl_w});
    chk("mab", 16'h1234, memory_address_bus);
    chk("mdb_drive", 16'h0000, {15'h0000, mdb_drive});
    u_jcb_jtag_host.shift(1'b0, 16'hC3A5, 16, got);
    chk("bypass", 16'h43A5, {1'b0, got[15:1]});
    chk("cpu_ctl", 16'h0001, {10'h000, ctl_w});
    chk("mdb", 16'h5A3C, memory_data_bus);
    @(negedge clk_in);
    fetch_in = 1'b0;
    sync_in = 1'b1;
    u_jcb_jtag_host.shift(1'b1, {8'h00, CTRL_READ_INSTR}, 8, got);
    u_jcb_jtag_host.shift(1'b0, 16'hFFFF, 16, got);
    chk("readback", 16'h2200, got);
    chk("cpu_ctl", 16'h0001, {10'h000, ctl_w});
    chk("tdo_oe", 16'h0000, {15'h0000, tdo_oe});
    // A reset in mid-run clears the data bus and sets the control word to its reset value.
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("mdb", 16'h0000, memory_data_bus);
    chk("cpu_ctl", 16'h0001, {10'h000, ctl_w});
    conclude();
  end
endmodule  // jcb_cpu_bus_ctl_tb
`default_nettype wire
